// ==== src/lfd_slave.sv ====
// Two-wire slave and control logic of a flash LED driver.
// Assumes SCL and SDA from an external master with pull-ups; pins are asynchronous.
module lfd_slave
  import lfd_pkg::*;
#(
  parameter int STEP_CYCLES = FLASH_STEP_CYCLES
)
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  lfd_link_if.dev         BUS,
  input  wire logic       FLASH_FIRE_PIN,
  input  wire logic       TX_MASK_PIN,
  input  wire logic       SUPPLY_LOW,
  input  wire logic [1:0] STRAP_SEL,
  output logic            FLASH_ON,
  output logic            CURRENT_CAP
);

  typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} lfd_slv_state_type;
  typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} lfd_phase_type;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lfd_slv_state_type st, next_st;
  lfd_phase_type     ph, next_ph;
  logic [3:0]  cnt, next_cnt;
  logic [7:0]  sr, next_sr;
  logic        rw, next_rw;
  logic        more, next_more;
  logic [7:0]  ptr, next_ptr;
  logic        sda_oe, next_sda_oe;
  logic [7:0]  cmd_reg, next_cmd_reg;
  logic [7:0]  level_reg, next_level_reg;
  logic [7:0]  aux_reg, next_aux_reg;
  logic [7:0]  status_reg, next_status_reg;
  logic        alert, next_alert;
  logic        flash_on, next_flash_on;
  logic        cap, next_cap;
  logic [3:0]  steps, next_steps;
  logic [31:0] pre, next_pre;
  logic [1:0]  addr_low, next_addr_low;
  logic        strap_taken, next_strap_taken;
  logic [2:0]  scl_q;
  logic [2:0]  sda_q;
  logic [2:0]  pin_q0;
  logic [2:0]  pin_q1;
  logic        scl_s, sda_s, start, stop, rise, fall;
  logic        fire_s, mask_s, sup_low, load, flash_act;
  logic [7:0]  rd_byte;

  // Register read mux; unmapped pointers read as zero
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] c,
                                          input logic [7:0] l, input logic [7:0] x,
                                          input logic [7:0] s);
    case (a)
      REG_CMD:    reg_read = c;
      REG_LEVEL:  reg_read = l;
      REG_AUX:    reg_read = x;
      REG_STATUS: reg_read = s;
      default:    reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage 0 feeds stage 1 only; stage 2 is the history for edge detection
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_q  <= 3'h7;
      sda_q  <= 3'h7;
      pin_q0 <= 3'h0;
      pin_q1 <= 3'h0;
    end else begin
      scl_q  <= {scl_q[1:0], BUS.scl};
      sda_q  <= {sda_q[1:0], BUS.sda};
      pin_q0 <= {SUPPLY_LOW, TX_MASK_PIN, FLASH_FIRE_PIN};
      pin_q1 <= pin_q0;
    end
  end

  assign scl_s   = scl_q[1];
  assign sda_s   = sda_q[1];
  assign fire_s  = pin_q1[0];
  assign mask_s  = pin_q1[1];
  assign sup_low = pin_q1[2];
  // Conditions need SCL high in both samples, so a skewed SCL edge is not misread
  assign start = scl_s & scl_q[2] & sda_q[2] & ~sda_s;
  assign stop  = scl_s & scl_q[2] & ~sda_q[2] & sda_s;
  assign rise  = scl_s & ~scl_q[2];
  assign fall  = ~scl_s & scl_q[2];
  assign rd_byte = reg_read(ptr, cmd_reg, level_reg, aux_reg, status_reg);
  assign flash_act = cmd_reg[PERMIT_BIT] & fire_s;

  // ----------------------------------------------------------------
  // Protocol, registers and flash timer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st; next_ph = ph; next_cnt = cnt; next_sr = sr; next_rw = rw;
    next_more = more; next_ptr = ptr; next_sda_oe = sda_oe;
    next_cmd_reg = cmd_reg; next_level_reg = level_reg; next_aux_reg = aux_reg;
    next_status_reg = status_reg; next_alert = alert;
    next_steps = steps; next_pre = pre; load = 1'b0;
    // Strap level is caught once, in the first clocked cycle after reset
    next_strap_taken = 1'b1;
    next_addr_low = strap_taken ? addr_low : STRAP_SEL;
    if (stop) begin
      next_st = S_IDLE; next_sda_oe = 1'b0;
    end else if (start) begin
      next_st = S_RX; next_ph = PH_ADDR; next_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else begin
      case (st)
        S_IDLE: ;
        S_RX: begin
          if (rise) begin
            next_sr = {sr[6:0], sda_s};                     // MSB first
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == 4'h8) begin
            next_cnt = 4'h0;
            if (sup_low) begin
              next_st = S_IDLE;                             // Withhold acknowledge
            end else if (ph == PH_ADDR && sr[7:1] != {ADDR_HIGH, addr_low}) begin
              next_st = S_IDLE;                             // Not ours
            end else begin
              next_st = S_RX_ACK;
              next_sda_oe = 1'b1;                           // Pull low over ack pulse
              case (ph)
                PH_ADDR: next_rw = sr[0];
                PH_REG:  next_ptr = sr;
                default: begin
                  case (ptr)
                    REG_CMD:   next_cmd_reg = sr;
                    REG_LEVEL: next_level_reg = sr;
                    REG_AUX:   next_aux_reg = sr;
                    default:   ;                            // Status is read only
                  endcase
                  next_ptr = ptr + 8'h01;
                end
              endcase
            end
          end
        end
        S_RX_ACK: begin
          if (fall) begin
            next_sda_oe = 1'b0;                             // Release while SCL low
            if (ph == PH_ADDR && rw) begin
              load = 1'b1;
            end else begin
              next_st = S_RX;
              next_ph = (ph == PH_ADDR) ? PH_REG : PH_DATA;
            end
          end
        end
        S_TX: begin
          if (fall) begin
            if (cnt == 4'h7) begin
              next_st = S_TX_ACK; next_sda_oe = 1'b0;
            end else begin
              next_cnt = cnt + 4'h1;
              next_sr = {sr[6:0], 1'b0};
              next_sda_oe = ~sr[6];
            end
          end
        end
        S_TX_ACK: begin
          if (rise) begin
            next_more = ~sda_s;
          end else if (fall) begin
            if (more) begin
              load = 1'b1;
            end else begin
              next_st = S_IDLE;                             // Master ends with stop
            end
          end
        end
        default: next_st = S_IDLE;
      endcase
    end
    // Start of a read byte: first bit goes out on this SCL fall
    if (load) begin
      next_st = S_TX; next_cnt = 4'h0; next_sr = rd_byte;
      next_sda_oe = ~rd_byte[7];
      next_ptr = ptr + 8'h01;
      if (ptr == REG_STATUS) begin
        next_alert = 1'b0;
        next_status_reg = 8'h00;
      end
    end
    // Flash duration: loaded while idle, counted down in 100 ms steps while active
    if (!flash_act) begin
      next_steps = cmd_reg[DUR_MSB:0];
      next_pre = 32'h0000_0000;
    end else if (steps == 4'h0) begin
      next_cmd_reg[PERMIT_BIT] = 1'b0;                      // Timer wins over a write
      next_status_reg[TIMEOUT_BIT] = 1'b1;                  // Set wins over read clear
      next_alert = 1'b1;
    end else if (pre == 32'(STEP_CYCLES - 1)) begin
      next_pre = 32'h0000_0000;
      next_steps = steps - 4'h1;
    end else begin
      next_pre = pre + 32'h0000_0001;
    end
    next_flash_on = flash_act & (steps != 4'h0);
    next_cap = level_reg[LEVEL_MSB_BIT] & mask_s;           // Only above 100 mA
  end

  // Everything clears at power-on reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= S_IDLE; ph <= PH_ADDR; cnt <= 4'h0; sr <= 8'h00; rw <= 1'b0;
      more <= 1'b0; ptr <= 8'h00; sda_oe <= 1'b0;
      cmd_reg <= REG_RESET; level_reg <= REG_RESET; aux_reg <= REG_RESET;
      status_reg <= REG_RESET; alert <= 1'b0; flash_on <= 1'b0; cap <= 1'b0;
      steps <= 4'h0; pre <= 32'h0000_0000; addr_low <= STRAP_GND;
      strap_taken <= 1'b0;
    end else begin
      st <= next_st; ph <= next_ph; cnt <= next_cnt; sr <= next_sr; rw <= next_rw;
      more <= next_more; ptr <= next_ptr; sda_oe <= next_sda_oe;
      cmd_reg <= next_cmd_reg; level_reg <= next_level_reg; aux_reg <= next_aux_reg;
      status_reg <= next_status_reg; alert <= next_alert; flash_on <= next_flash_on;
      cap <= next_cap; steps <= next_steps; pre <= next_pre;
      addr_low <= next_addr_low; strap_taken <= next_strap_taken;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain pins only ever pull low
  assign BUS.dev_sda_o    = 1'b0;
  assign BUS.dev_sda_oe   = sda_oe;
  assign BUS.dev_alert_o  = 1'b0;
  assign BUS.dev_alert_oe = alert;
  assign FLASH_ON         = flash_on;
  assign CURRENT_CAP      = cap;

endmodule : lfd_slave

// ==== src/lfd_pkg.sv ====
// Shared constants for the flash LED driver two-wire slave and its master.
// Assumes a 100 MHz system clock on both ends.
package lfd_pkg;

  // ----------------------------------------------------------------
  // Slave addressing
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_HIGH    = 5'h0c; // Fixed upper bits 01100
  localparam logic [1:0] STRAP_GND    = 2'h0;
  localparam logic [1:0] STRAP_SUPPLY = 2'h1;
  localparam logic [1:0] STRAP_SDA    = 2'h2;
  localparam logic [1:0] STRAP_SCL    = 2'h3;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_LEVEL     = 8'h01;
  localparam logic [7:0] REG_AUX       = 8'h02;
  localparam logic [7:0] REG_STATUS    = 8'h03;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         PERMIT_BIT    = 6;
  localparam int         DUR_MSB       = 3;
  localparam int         LEVEL_MSB_BIT = 3;
  localparam int         TIMEOUT_BIT   = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS             = 10;
  localparam int FLASH_STEP_MS      = 100;
  localparam int FLASH_STEP_CYCLES  = FLASH_STEP_MS * 1000000 / CLK_NS;
  localparam int SCL_PERIOD_NS      = 4000;  // 250 kHz keeps every transfer short
  localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_NS);

endpackage : lfd_pkg

// ==== src/lfd_link_if.sv ====
// Two-wire link between the LED driver slave and its bus master.
// Assumes external pull-ups: a released line reads high.
interface lfd_link_if;

  // ----------------------------------------------------------------
  // Driver signals
  // ----------------------------------------------------------------
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_alert_o;
  logic dev_alert_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;

  // ----------------------------------------------------------------
  // Resolved wire levels (wired AND with pull-up)
  // ----------------------------------------------------------------
  logic scl;
  logic sda;
  logic alert_n;
  assign scl     = host_scl_oe ? host_scl_o : 1'b1;
  assign sda     = (dev_sda_oe ? dev_sda_o : 1'b1) & (host_sda_oe ? host_sda_o : 1'b1);
  assign alert_n = dev_alert_oe ? dev_alert_o : 1'b1;

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe,
    output dev_alert_o,
    output dev_alert_oe
  );

  modport host (
    input  scl,
    input  sda,
    input  alert_n,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );

endinterface : lfd_link_if

// ==== src/lfd_master.sv ====
// Two-wire bus master: one register write or one register read per command.
// Assumes the slave end on the same link interface; makes SCL by a divider.
module lfd_master
  import lfd_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  lfd_link_if.host        BUS,
  input  wire logic       CMD_VALID,
  input  wire logic       CMD_READ,
  input  wire logic [1:0] CMD_ADDR_LOW,
  input  wire logic [7:0] CMD_REG,
  input  wire logic [7:0] CMD_DATA,
  output logic            CMD_READY,
  output logic            DONE,
  output logic            NACK,
  output logic [7:0]      RD_DATA,
  output logic            ALERT
);

  typedef enum logic [2:0] {M_IDLE, M_START, M_TX, M_RX, M_STOP} lfd_mst_state_type;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lfd_mst_state_type st, next_st;
  logic [15:0] qcnt, next_qcnt;
  logic [1:0]  phase, next_phase;
  logic [1:0]  step, next_step;
  logic [3:0]  bitn, next_bitn;
  logic [7:0]  sr, next_sr;
  logic        rd, next_rd;
  logic [1:0]  alow, next_alow;
  logic [7:0]  rega, next_rega;
  logic [7:0]  wdat, next_wdat;
  logic        ack_ok, next_ack_ok;
  logic        scl_oe, next_scl_oe;
  logic        sda_oe, next_sda_oe;
  logic        ready, next_ready;
  logic        done, next_done;
  logic        nack, next_nack;
  logic [7:0]  rdata, next_rdata;
  logic [1:0]  sda_q;
  logic [1:0]  alert_q;
  logic        tick;

  // Byte sent in each addressed step: address+write, register, data, address+read
  function automatic logic [7:0] tx_byte(input logic [1:0] s, input logic [1:0] lo,
                                         input logic [7:0] r, input logic [7:0] d);
    case (s)
      2'h0:    tx_byte = {ADDR_HIGH, lo, 1'b0};
      2'h1:    tx_byte = r;
      2'h2:    tx_byte = d;
      default: tx_byte = {ADDR_HIGH, lo, 1'b1};
    endcase
  endfunction : tx_byte

  // Quarter-bit tick: SCL has four phases per bit
  assign tick = (qcnt == 16'(SCL_QUARTER_CYCLES - 1));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st; next_qcnt = qcnt; next_phase = phase; next_step = step;
    next_bitn = bitn; next_sr = sr; next_rd = rd; next_alow = alow;
    next_rega = rega; next_wdat = wdat; next_ack_ok = ack_ok;
    next_scl_oe = scl_oe; next_sda_oe = sda_oe; next_ready = ready;
    next_done = 1'b0; next_nack = nack; next_rdata = rdata;
    if (st == M_IDLE) begin
      next_qcnt = 16'h0000;
      next_phase = 2'h0;
      if (CMD_VALID) begin
        next_st = M_START; next_ready = 1'b0; next_nack = 1'b0;
        next_rd = CMD_READ; next_alow = CMD_ADDR_LOW;
        next_rega = CMD_REG; next_wdat = CMD_DATA; next_step = 2'h0;
      end
    end else begin
      next_qcnt = tick ? 16'h0000 : qcnt + 16'h0001;
    end
    if (tick && st != M_IDLE) begin
      next_phase = phase + 2'h1;
      case (st)
        M_START: begin // Also serves as repeated start from SCL low
          case (phase)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1; // SDA falls while SCL high
            default: begin
              next_scl_oe = 1'b1; next_st = M_TX; next_bitn = 4'h0;
              next_sr = tx_byte(step, alow, rega, wdat);
            end
          endcase
        end
        M_TX: begin
          case (phase)
            2'h0: next_sda_oe = (bitn == 4'h8) ? 1'b0 : ~sr[7]; // SCL low
            2'h1: next_scl_oe = 1'b0;
            2'h2: if (bitn == 4'h8) next_ack_ok = ~sda_q[1];
            default: begin
              next_scl_oe = 1'b1;
              if (bitn != 4'h8) begin
                next_bitn = bitn + 4'h1; next_sr = {sr[6:0], 1'b0};
              end else if (!ack_ok) begin
                next_nack = 1'b1; next_st = M_STOP; // Abort on no acknowledge
              end else if (!rd && step == 2'h2) begin
                next_st = M_STOP;
              end else if (rd && step == 2'h1) begin
                next_step = 2'h3; next_st = M_START;
              end else if (rd && step == 2'h3) begin
                next_st = M_RX; next_bitn = 4'h0;
              end else begin
                next_step = step + 2'h1; next_bitn = 4'h0;
                next_sr = tx_byte(step + 2'h1, alow, rega, wdat);
              end
            end
          endcase
        end
        M_RX: begin
          case (phase)
            2'h0: next_sda_oe = 1'b0; // Ninth bit released: no acknowledge
            2'h1: next_scl_oe = 1'b0;
            2'h2: if (bitn != 4'h8) next_sr = {sr[6:0], sda_q[1]};
            default: begin
              next_scl_oe = 1'b1;
              if (bitn == 4'h8) begin
                next_rdata = sr; next_st = M_STOP;
              end else begin
                next_bitn = bitn + 4'h1;
              end
            end
          endcase
        end
        M_STOP: begin // Stop ends each command before the next command's start
          case (phase)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            default: begin
              next_st = M_IDLE; next_done = 1'b1; next_ready = 1'b1;
            end
          endcase
        end
        default: next_st = M_IDLE;
      endcase
    end
  end

  // Lines released in idle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= M_IDLE; qcnt <= 16'h0000; phase <= 2'h0; step <= 2'h0;
      bitn <= 4'h0; sr <= 8'h00; rd <= 1'b0; alow <= 2'h0;
      rega <= 8'h00; wdat <= 8'h00; ack_ok <= 1'b0; scl_oe <= 1'b0;
      sda_oe <= 1'b0; ready <= 1'b1; done <= 1'b0; nack <= 1'b0;
      rdata <= 8'h00; sda_q <= 2'h3; alert_q <= 2'h0;
    end else begin
      st <= next_st; qcnt <= next_qcnt; phase <= next_phase; step <= next_step;
      bitn <= next_bitn; sr <= next_sr; rd <= next_rd; alow <= next_alow;
      rega <= next_rega; wdat <= next_wdat; ack_ok <= next_ack_ok;
      scl_oe <= next_scl_oe; sda_oe <= next_sda_oe; ready <= next_ready;
      done <= next_done; nack <= next_nack; rdata <= next_rdata;
      sda_q <= {sda_q[0], BUS.sda};
      alert_q <= {alert_q[0], ~BUS.alert_n}; // Kept active high so ALERT leaves a flop
    end
  end

  assign BUS.host_scl_o  = 1'b0;
  assign BUS.host_sda_o  = 1'b0;
  assign BUS.host_scl_oe = scl_oe;
  assign BUS.host_sda_oe = sda_oe;
  assign CMD_READY       = ready;
  assign DONE            = done;
  assign NACK            = nack;
  assign RD_DATA         = rdata;
  assign ALERT           = alert_q[1];

endmodule : lfd_master

// ==== verification/lfd_link_assertions.sv ====
// Concurrent checks on the slave side of the two-wire link.
// Assumes the link interface signals as inputs and one clock domain.
module lfd_link_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic dev_alert_oe,
  input wire logic host_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Slave pin behaviour
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // Both open-drain pins leave reset released
  property p_reset_release;
    $rose(RST_N) |-> !dev_sda_oe && !dev_alert_oe;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("pins driven after reset");
  // Slave data may only move while the clock is low
  property p_sda_stable;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("slave sda moved, scl high");
  // A pull is launched some cycles into the low phase, after the synchroniser
  property p_pull_late;
    $rose(dev_sda_oe) |-> !scl && !$past(scl, 3);
  endproperty
  a_pull_late: assert property (p_pull_late) else $error("slave pull too early");
  // Once pulled, the line is held for at least eight more cycles, not a glitch
  property p_pull_hold;
    $rose(dev_sda_oe) |-> ##1 dev_sda_oe [*8];
  endproperty
  a_pull_hold: assert property (p_pull_hold) else $error("slave pull too short");
  // Alert is released only while the slave sends a byte
  property p_alert_clear;
    $fell(dev_alert_oe) |-> !host_sda_oe && !scl;
  endproperty
  a_alert_clear: assert property (p_alert_clear) else $error("alert released outside read");
  // Alert is a level, not a pulse
  property p_alert_hold;
    $rose(dev_alert_oe) |-> ##1 dev_alert_oe [*8];
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert too short");
  // After a stop the slave leaves the bus idle
  property p_stop_idle;
    scl && $past(scl) && $rose(sda) |-> ##1 !dev_sda_oe [*4];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("slave pulls after stop");
  // A start never meets a slave pull
  property p_start_free;
    scl && $past(scl) && $fell(sda) |-> ##1 !dev_sda_oe [*3];
  endproperty
  a_start_free: assert property (p_start_free) else $error("slave pulls after start");
  c_pull: cover property ($rose(dev_sda_oe));
  c_alert_set: cover property ($rose(dev_alert_oe));
  c_alert_clear: cover property ($fell(dev_alert_oe));
endmodule : lfd_link_assertions

// ==== verification/testbench.sv ====
// Self-checking bench: master and slave joined on one link, driven by commands.
// Assumes a 100 MHz clock; the slave flash step is shortened to 20 cycles.
module testbench
  import lfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, cmd_valid, cmd_read, cmd_ready, done, nack, alert, ack_bit;
  logic       fire, tx_mask, supply_low, flash_on, current_cap;
  logic [1:0] strap_sel, cmd_addr_low;
  logic [7:0] cmd_reg, cmd_data, rd_data, first_byte;
  int         fails, total_checks, cycles, nbits;
  lfd_link_if u_lfd_link_if ();
  lfd_master u_lfd_master (.CLK(clk), .RST_N(rst_n), .BUS(u_lfd_link_if), .CMD_VALID(cmd_valid),
    .CMD_READ(cmd_read), .CMD_ADDR_LOW(cmd_addr_low), .CMD_REG(cmd_reg), .CMD_DATA(cmd_data),
    .CMD_READY(cmd_ready), .DONE(done), .NACK(nack), .RD_DATA(rd_data), .ALERT(alert));
  lfd_slave #(.STEP_CYCLES(20)) u_lfd_slave (.CLK(clk), .RST_N(rst_n), .BUS(u_lfd_link_if),
    .FLASH_FIRE_PIN(fire), .TX_MASK_PIN(tx_mask), .SUPPLY_LOW(supply_low), .STRAP_SEL(strap_sel),
    .FLASH_ON(flash_on), .CURRENT_CAP(current_cap));
  lfd_link_assertions u_lfd_link_assertions (.CLK(clk), .RST_N(rst_n), .scl(u_lfd_link_if.scl),
    .sda(u_lfd_link_if.sda), .dev_sda_oe(u_lfd_link_if.dev_sda_oe),
    .dev_alert_oe(u_lfd_link_if.dev_alert_oe), .host_sda_oe(u_lfd_link_if.host_sda_oe));

  // ----------------------------------------------------------------
  // Clock, wire monitor, timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Shift in the first byte after each start and its acknowledge bit
  always @(posedge u_lfd_link_if.scl) begin
    if (nbits < 8) first_byte = {first_byte[6:0], u_lfd_link_if.sda};
    if (nbits == 8) ack_bit = u_lfd_link_if.sda;
    nbits++;
  end
  always @(negedge u_lfd_link_if.sda) if (u_lfd_link_if.scl) nbits = 0;
  // The six transfers take about 63k cycles in all, so 80k bounds the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One command, held for one clock edge, then wait for done
  task automatic xfer(input logic rd, input logic [1:0] al, input logic [7:0] r,
                      input logic [7:0] d);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr_low = al;
    cmd_reg = r;
    cmd_data = d;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    do begin
      @(posedge clk);
      #1;
    end while (done !== 1'b1);
  endtask : xfer
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, cmd_valid, cmd_read, fire, supply_low, nbits, ack_bit} = '0;
    {cmd_addr_low, cmd_reg, cmd_data, first_byte} = '0;
    tx_mask = 1'b1;
    strap_sel = STRAP_SDA;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    check("idle", 8'h03, {6'h00, u_lfd_link_if.scl, u_lfd_link_if.sda});
    xfer(1'b0, STRAP_SDA, REG_LEVEL, 8'h08);
    check("address", {ADDR_HIGH, STRAP_SDA, 1'b0}, first_byte);
    check("ack", 8'h00, {7'h00, ack_bit});
    check("nack", 8'h00, {7'h00, nack});
    check("cap", 8'h01, {7'h00, current_cap});
    check("ready", 8'h01, {7'h00, cmd_ready});
    tx_mask = 1'b0;
    repeat (5) @(posedge clk);
    #1 check("cap", 8'h00, {7'h00, current_cap});
    xfer(1'b0, STRAP_SUPPLY, REG_LEVEL, 8'h00);
    check("ack", 8'h01, {7'h00, ack_bit});
    check("nack", 8'h01, {7'h00, nack});
    supply_low = 1'b1;
    xfer(1'b0, STRAP_SDA, REG_CMD, 8'h42);
    supply_low = 1'b0;
    check("nack", 8'h01, {7'h00, nack});
    // Permit set with fire pin low: no flash until the pin rises
    xfer(1'b0, STRAP_SDA, REG_CMD, 8'h42);
    check("flash", 8'h00, {7'h00, flash_on});
    fire = 1'b1;
    repeat (5) @(posedge clk);
    #1 check("flash", 8'h01, {7'h00, flash_on});
    check("alert", 8'h00, {7'h00, alert});
    repeat (60) @(posedge clk);
    #1 check("flash", 8'h00, {7'h00, flash_on});
    check("alert", 8'h01, {7'h00, alert});
    xfer(1'b1, STRAP_SDA, REG_STATUS, 8'h00);
    check("address", {ADDR_HIGH, STRAP_SDA, 1'b1}, first_byte);
    check("status", 8'h01, rd_data);
    repeat (5) @(posedge clk);
    #1 check("alert", 8'h00, {7'h00, alert});
    xfer(1'b1, STRAP_SDA, REG_CMD, 8'h00);
    check("command", 8'h02, rd_data);
    print_verdict();
  end
endmodule : testbench
